//--- srr_pkg.sv
// Shared constants and frame layouts for the register read response path
package srr_pkg;

  localparam int unsigned FRAME_BITS  = 32;
  localparam int unsigned CNT_W       = 6;
  localparam logic [5:0]  CNT_FULL    = 6'h20;  // Bits in a complete frame
  localparam logic [5:0]  CNT_ADDR    = 6'h0f;  // Count at the sixteenth rising edge
  localparam logic [3:0]  CMD_REG_RD  = 4'hc;   // Register read request code
  localparam logic [1:0]  ST_ERROR    = 2'h3;   // Basic status in an error frame
  localparam logic [31:0] TX_RESET    = 32'h0000_0000;
  localparam logic [6:0]  ADDR_RESET  = 7'h00;
  localparam logic [23:0] PAYLD_RESET = 24'h00_0000;

  // Host request frame
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] fixed;
    logic [6:0] word_addr;
    logic       byte_sel;
    logic [7:0] data;
    logic [7:0] crc;
  } srr_req_type;

  // Normal read reply frame
  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] basic_status_field;
    logic [1:0] unused;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic [7:0] crc;
  } srr_reply_type;

  // Error reply frame for a register request
  typedef struct packed {
    logic [3:0]  cmd;
    logic [1:0]  basic_status_field;
    logic [15:0] unused;
    logic [1:0]  detailed_status_field;
    logic [7:0]  crc;
  } srr_err_type;

  // Command echo: C[0] moves to the top, C[3:1] follow
  function automatic logic [3:0] srr_echo(input logic [3:0] c);
    srr_echo = {c[0], c[3:1]};
  endfunction : srr_echo

endpackage : srr_pkg

//--- srr_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module srr_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // One pair of flops per bit; the first stage feeds only the second.
  // Reset loads each pin's idle level so no false edge follows reset.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          meta_reg[i] <= reset_val[i];
          sync_out[i] <= reset_val[i];
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule : srr_sync
`default_nettype wire

//--- srr_spi_read_resp.sv
// SPI client register read decode and reply frame generation
// Functional notes
// - The register is chosen by the upper seven address bits only, the byte select bit is ignored.
// - A read request is a frame whose four top bits are 1100.
// - A normal read reply goes out in the next frame only when no framing or output check fault.
// - With either fault present, an error frame replaces the register contents.
// - The returned value is the one held when select rises at the end of the request.
// - The error frame holds the echoed command, status 11, zero data, detailed status and checksum.
// - A good reply holds code 0110, basic status, two zeros, high byte, low byte, checksum.
// - Clock idles low, data is sampled on rising and changed on falling edges, MSB first.
`timescale 1ns/100ps
`default_nettype none
module srr_spi_read_resp (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         sclk,
  input  wire logic         ss_n,
  input  wire logic         mosi,
  output var  logic         miso,
  output var  logic         miso_oe_n,
  input  wire logic         spi_err,
  input  wire logic         miso_err,
  input  wire logic [1:0]   basic_status,
  input  wire logic [1:0]   detailed_status,
  output var  logic [6:0]   reg_rd_addr,
  input  wire logic [15:0]  reg_rd_data,
  output var  logic [23:0]  crc_payload,
  input  wire logic [7:0]   crc_in,
  output var  logic         read_taken,
  output var  logic         read_error
);

  import srr_pkg::*;

  logic [2:0]        pins_sync;
  logic              sclk_s;
  logic              ss_n_s;
  logic              mosi_s;
  logic              sclk_d_reg;
  logic              ss_n_d_reg;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              ss_fall;
  logic              ss_rise;
  logic [31:0]       rx_reg;
  logic [31:0]       tx_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              err_seen_reg;
  logic              crc_pend_reg;
  logic              fault_now;
  logic              read_hit;
  srr_req_type       req;
  srr_reply_type     reply;
  srr_err_type       err_frame;

  // Pin inputs pass two flops before any logic reads them
  srr_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .async_in  ({sclk, ss_n, mosi}),
    .reset_val (3'h2),
    .sync_out  (pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign ss_n_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // Edge history of the synchronised clock and select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
      ss_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      ss_n_d_reg <= ss_n_s;
    end
  end

  // Clock edges count only while selected; idle-low clock assumed
  assign sclk_rise = !ss_n_s && sclk_s && !sclk_d_reg;
  assign sclk_fall = !ss_n_s && !sclk_s && sclk_d_reg;
  assign ss_fall   = !ss_n_s && ss_n_d_reg;
  assign ss_rise   = ss_n_s && !ss_n_d_reg;

  // Decode of the received request
  assign req       = srr_req_type'(rx_reg);
  assign fault_now = err_seen_reg || spi_err || miso_err || (cnt_reg != CNT_FULL);
  assign read_hit  = (req.cmd == CMD_REG_RD);

  // Reply layouts built from the captured register pair and status
  always_comb begin
    reply.cmd                = srr_echo(CMD_REG_RD);
    reply.basic_status_field = basic_status;
    reply.unused             = 2'h0;
    reply.high_byte          = reg_rd_data[15:8];
    reply.low_byte           = reg_rd_data[7:0];
    reply.crc                = 8'h00;
    err_frame.cmd                   = srr_echo(req.cmd);
    err_frame.basic_status_field    = ST_ERROR;
    err_frame.unused                = 16'h0000;
    err_frame.detailed_status_field = detailed_status;
    err_frame.crc                   = 8'h00;
  end

  // Receive shift register, MSB first, sampled on rising clock edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_reg  <= TX_RESET;
      cnt_reg <= '0;
    end else if (ss_fall) begin
      cnt_reg <= '0;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[30:0], mosi_s};
      if (cnt_reg != CNT_FULL) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  // Word address latched once bits 23 to 17 have arrived
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rd_addr <= ADDR_RESET;
    end else if (sclk_rise && cnt_reg == CNT_ADDR) begin
      reg_rd_addr <= rx_reg[6:0];
    end
  end

  // Sticky fault flag for the frame; a new fault wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_seen_reg <= 1'b0;
    end else if (spi_err || miso_err) begin
      err_seen_reg <= 1'b1;
    end else if (ss_fall) begin
      err_seen_reg <= 1'b0;
    end
  end

  // Reply load at select rise, checksum merge one cycle later, shift out on falling edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_reg       <= TX_RESET;
      crc_payload  <= PAYLD_RESET;
      crc_pend_reg <= 1'b0;
    end else if (ss_rise) begin
      crc_pend_reg <= 1'b1;
      if (read_hit && !fault_now) begin
        tx_reg      <= 32'(reply);
        crc_payload <= reply[31:8];
      end else if (read_hit) begin
        tx_reg      <= 32'(err_frame);
        crc_payload <= err_frame[31:8];
      end else begin
        tx_reg      <= TX_RESET;
        crc_payload <= PAYLD_RESET;
      end
    end else if (crc_pend_reg) begin
      crc_pend_reg <= 1'b0;
      tx_reg[7:0]  <= crc_in;
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[30:0], 1'b0};
    end
  end

  // Data pin: top bit on select fall, next bit after each falling edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= ss_n_s;
      if (ss_fall) begin
        miso <= tx_reg[31];
      end else if (sclk_fall) begin
        miso <= tx_reg[30];
      end
    end
  end

  // One-cycle report of each accepted read request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      read_taken <= 1'b0;
      read_error <= 1'b0;
    end else begin
      read_taken <= ss_rise && read_hit;
      read_error <= ss_rise && read_hit && fault_now;
    end
  end

endmodule : srr_spi_read_resp
`default_nettype wire

//--- srr_asserts.sv
// Checker for the register read reply path
`timescale 1ns/100ps
`default_nettype none
module srr_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sclk,
  input wire logic        ss_n,
  input wire logic        mosi,
  input wire logic        miso,
  input wire logic        miso_oe_n,
  input wire logic        spi_err,
  input wire logic        miso_err,
  input wire logic [1:0]  basic_status,
  input wire logic [1:0]  detailed_status,
  input wire logic [6:0]  reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic [23:0] crc_payload,
  input wire logic [7:0]  crc_in,
  input wire logic        read_taken,
  input wire logic        read_error
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Select has risen and stayed up
  sequence s_end;
    $rose(ss_n) ##1 ss_n;
  endsequence
  sequence s_good;
    read_taken && !read_error;
  endsequence
  a_err_taken: assert property (read_error |-> read_taken)
    else $error("error pulse without request");
  a_pulse_one: assert property (read_taken |=> !read_taken)
    else $error("taken pulse too long");
  a_oe_release: assert property (s_end |-> ##[1:6] miso_oe_n)
    else $error("output kept after frame");
  a_err_frame: assert property (read_error |-> crc_payload[23:2] == 22'h1b0000)
    else $error("bad error frame");
  a_good_frame: assert property (s_good |-> crc_payload[23:20] == 4'h6
    && crc_payload[17:16] == 2'h0) else $error("bad reply head");
  a_data_held: assert property (s_good |-> crc_payload[15:0] == $past(reg_rd_data)
    && crc_payload[19:18] == $past(basic_status)) else $error("reply not from select rise");
  a_fault_err: assert property (read_taken && ($past(spi_err) || $past(miso_err))
    |-> read_error) else $error("fault gave normal reply");
  a_addr_hold: assert property ($changed(reg_rd_addr) |-> !ss_n && !$past(ss_n, 3))
    else $error("address moved outside frame");
  a_oe_drive: assert property ($fell(ss_n) |-> ##[2:4] !miso_oe_n)
    else $error("output not enabled in frame");
endmodule : srr_asserts
bind srr_spi_read_resp srr_asserts srr_asserts_inst (.*);
`default_nettype wire

//--- srr_host.sv
// SPI host partner model driving 32-bit frames
`timescale 1ns/100ps
`default_nettype none
module srr_host (
  input  wire logic ref_clk,
  output var  logic sclk,
  output var  logic ss_n,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame, clock idle low, change on fall, MSB first
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    ss_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (20) @(posedge ref_clk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (20) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (20) @(posedge ref_clk);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (10) @(posedge ref_clk);
  endtask : xfer
endmodule : srr_host
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the register read reply path
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import srr_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, spi_err = 1'b0, miso_err = 1'b0, bank = 1'b0;
  logic sclk, ss_n, mosi, miso, miso_oe_n, read_taken, read_error;
  logic [1:0] basic_status = 2'h1, detailed_status = 2'h2;
  logic [6:0] reg_rd_addr;
  logic [15:0] reg_rd_data = 16'h0000;
  logic [23:0] crc_payload;
  logic [7:0] crc_in;
  logic [31:0] rx;
  int num_errors = 0, checks = 0, taken = 0, errs = 0;
  function automatic logic [7:0] ck(input logic [23:0] p);
    return p[23:16] ^ p[15:8] ^ p[7:0];
  endfunction : ck
  function automatic logic [15:0] regv(input logic [6:0] a, input logic b);
    return {1'b1, a, b, ~a};
  endfunction : regv
  function automatic logic [31:0] req(input logic [7:0] a);
    return {4'hc, 4'h0, a, 8'h00, ck({4'hc, 4'h0, a, 8'h00})};
  endfunction : req
  function automatic logic [31:0] good(input logic [6:0] a, input logic b, input logic [1:0] s);
    return {4'h6, s, 2'h0, regv(a, b), ck({4'h6, s, 2'h0, regv(a, b)})};
  endfunction : good
  function automatic logic [31:0] bad(input logic [1:0] d);
    return {4'h6, 2'h3, 16'h0, d, ck({4'h6, 2'h3, 16'h0, d})};
  endfunction : bad
  srr_host srr_host_inst (.ref_clk(ref_clk), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso));
  srr_spi_read_resp srr_spi_read_resp_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
    .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .spi_err(spi_err),
    .miso_err(miso_err), .basic_status(basic_status), .detailed_status(detailed_status),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .crc_payload(crc_payload),
    .crc_in(crc_in), .read_taken(read_taken), .read_error(read_error));
  // Outside checksum logic
  always_comb crc_in = ck(crc_payload);
  // Register map and pulse counters
  always @(posedge ref_clk) begin
    reg_rd_data <= regv(reg_rd_addr, bank);
    taken <= taken + (read_taken === 1'b1);
    errs <= errs + (read_error === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_read();
    chk(miso_oe_n, 1'b1);
    srr_host_inst.xfer(req(8'h5a), rx);
    chk(rx, 32'h0);
    srr_host_inst.xfer(req(8'h5b), rx);
    chk(rx, good(7'h2d, 1'b0, 2'h1));
    bank <= 1'b1;
    basic_status <= 2'h2;
    srr_host_inst.xfer(req(8'h00), rx);
    chk(rx, good(7'h2d, 1'b0, 2'h1));
    srr_host_inst.xfer(32'h8000_0000, rx);
    chk(rx, good(7'h00, 1'b1, 2'h2));
    chk(taken, 3);
  endtask : t_read
  task automatic t_fault();
    spi_err <= 1'b1;
    srr_host_inst.xfer(req(8'h10), rx);
    chk(rx, 32'h0);
    spi_err <= 1'b0;
    miso_err <= 1'b1;
    detailed_status <= 2'h1;
    srr_host_inst.xfer(req(8'h12), rx);
    chk(rx, bad(2'h2));
    miso_err <= 1'b0;
    srr_host_inst.xfer(32'h0, rx);
    chk(rx, bad(2'h1));
    srr_host_inst.xfer(req(8'h20), rx);
    chk(rx, 32'h0);
    chk(errs, 2);
    chk(taken, 6);
  endtask : t_fault
  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_read();
    t_fault();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
